// ---- cmd_host.sv ----
/*
 Command host model: issues one request per call on the command port.
 Assumes the port samples on the rising edge; drives on the falling edge.
*/
`timescale 1ns/1ps
module cmd_host
(
   input  wire logic            ref_clk,
   output      flash_pkg::req_t req
);
   initial req = '{valid: 1'b0, cmd: flash_pkg::cmd_read, addr: 24'hA5A5A5, data: 8'h5A};

   // One cycle strobe, then addr and data flip so stale values never match
   task automatic send(input flash_pkg::cmd_t c, input logic [23:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req <= '{valid: 1'b1, cmd: c, addr: a, data: d};
      @(negedge ref_clk);
      req <= '{valid: 1'b0, cmd: c, addr: ~a, data: ~d};
   endtask
endmodule

// ---- disc_rom.sv ----
/*
 Read-only discovery space of 256 bytes; undefined bytes read erased.
 Assumes a 24-bit byte address; anything above the space reads erased.
*/
`timescale 1ns/1ps
`include "flash_map.svh"
module disc_rom
#(
   parameter logic [7:0] VENDOR_ID = 8'hA5  // Arbitrary value
)
(
   input  wire logic [23:0] addr,
   output      logic [7:0]  data
);

   logic [23:0] ofs;

   always_comb
   begin
      ofs  = 24'h0;
      data = `ERASED;
      if (addr <= `DISC_HDR0_LAST)
      begin
         data = 8'(`DISC_HDR0 >> {addr[3:0], 3'b000});
      end
      else if (addr == `DISC_ID_ADDR)
      begin
         data = VENDOR_ID;
      end
      else if (addr >= `DISC_HDR1_BASE && addr <= `DISC_HDR1_LAST)
      begin
         ofs  = addr - `DISC_HDR1_BASE;
         data = 8'(`DISC_HDR1 >> {ofs[2:0], 3'b000});
      end
      else if (addr >= `DISC_PTAB_BASE && addr <= `DISC_PTAB_LAST)
      begin
         ofs  = addr - `DISC_PTAB_BASE;
         data = 8'(`DISC_PTAB >> {ofs[1:0], 3'b000});
      end
   end

endmodule

// ---- flash_map.svh ----
/*
 Address map, command codes and discovery table contents of the flash store.
 Assumes inclusion by the package and by the storage core; definitions only.
*/
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// Main array geometry, 24-bit byte address
`define SECTOR_LAST_OFS  12'hFFF
`define BLOCK_LAST_OFS   16'hFFFF
`define CHIP_FIRST       24'h000000
`define CHIP_LAST        24'hFFFFFF

// Security register space, bits 23:12 select the register
`define SEC_FIRST        12'h001
`define SEC_LAST         12'h003
`define SEC_ERASE_LAST   24'h0003FF

// Command codes
`define OP_READ          8'hA0
`define OP_PAGE_PROG     8'hA2
`define OP_PROG_DATA     8'hA1
`define OP_SECTOR_ERASE  8'h20
`define OP_BLOCK_ERASE   8'hB1
`define OP_CHIP_ERASE    8'hB2
`define OP_SEC_READ      8'hC1
`define OP_SEC_PROG      8'hC2
`define OP_SEC_ERASE     8'hC3
`define OP_SEC_LOCK      8'hC4
`define OP_READ_DISC     8'h5A

// Discovery space, byte n at bits 8n+7:8n
`define DISC_HDR0        128'hFF000030_10010700_FF010108_50444653
`define DISC_HDR0_LAST   24'h00000F
`define DISC_ID_ADDR     24'h000010
`define DISC_HDR1_BASE   24'h000011
`define DISC_HDR1        56'hFF000070030100
`define DISC_HDR1_LAST   24'h000017
`define DISC_PTAB_BASE   24'h000030
`define DISC_PTAB        32'hFFF120E5
`define DISC_PTAB_LAST   24'h000033
`define ERASED           8'hFF

`endif

// ---- flash_map_and_discovery_table.sv ----
/*
 Flash storage core: 16 MB main array, three lockable security registers
 and the read-only discovery space, driven by a synchronous command port.
 Assumes the serial front end has already decoded commands into req.
*/
// What this block does
// - 16 MB as blocks, sectors, pages
// - Program within one page, ones to zeros
// - Erase sector, block or chip only
// - Sectors aligned on address bits 23:12
// - Three 1 KB security registers, own space
// - Lock bit permanently blocks program and erase
// - Security registers independent of each other
// - Discovery read returns discovery space bytes
// - Discovery space never written by host
// - Header, table at 30h, reserved above
// - Signature bytes at 00h to 03h
// - Minor 08h, major 01h revision
// - Header count 01h, protocol FFh
// - First header ID 00h, minor 07h
// - First header length 10h, pointer 30h
`timescale 1ns/1ps
`include "flash_map.svh"
module flash_map_and_discovery_table
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire flash_pkg::req_t  req,
   output      flash_pkg::resp_t resp,
   output      logic             busy
);

   typedef enum logic [1:0] {st_idle, st_erase, st_sec_erase} state_t;
   localparam logic [127:0] HDR0 = `DISC_HDR0;
   logic [7:0]  mem [16777216];
   state_t      st_r;
   state_t      st_nxt;
   logic [23:0] cur_r;
   logic [23:0] last_r;
   logic [1:0]  sel_r;
   logic [15:0] page_r;
   logic [7:0]  off_r;
   logic        open_r;
   logic        busy_r;
   flash_pkg::resp_t resp_r;
   logic        mwe;
   logic        mfill;
   logic [23:0] mwa;
   logic [2:0]  swe;
   logic        sfill;
   logic [9:0]  swa;
   logic [2:0]  slock;
   logic [2:0]  locked;
   logic [7:0]  srd [3];
   logic [7:0]  drd;
   logic        rej;
   logic        rd_ok;
   logic [7:0]  rd_byte;
   logic        fin;
   logic        sec_ok;
   logic [1:0]  sn;
   logic        idle_req;
   logic        disc_rd;

   assign idle_req = (st_r == st_idle) && req.valid;
   assign disc_rd  = idle_req && (req.cmd == flash_pkg::read_discovery_table_cmd);
   // Security space decode
   assign sec_ok   = (req.addr[23:12] >= `SEC_FIRST) && (req.addr[23:12] <= `SEC_LAST)
                     && (req.addr[11:10] == 2'h0);
   assign sn       = req.addr[13:12] - 2'h1;

   // Command decode and write steering
   always_comb
   begin
      mwe     = 1'b0;
      mfill   = 1'b0;
      mwa     = cur_r;
      swe     = 3'h0;
      sfill   = 1'b0;
      swa     = cur_r[9:0];
      slock   = 3'h0;
      rej     = 1'b0;
      rd_ok   = 1'b0;
      rd_byte = `ERASED;
      fin     = 1'b0;
      st_nxt  = st_r;
      unique case (st_r)
         st_erase:
         begin
            mwe   = 1'b1;
            mfill = 1'b1;
            rej   = req.valid;
            if (cur_r == last_r)
            begin
               st_nxt = st_idle;
               fin    = 1'b1;
            end
         end
         st_sec_erase:
         begin
            swe[sel_r] = 1'b1;
            sfill      = 1'b1;
            rej        = req.valid;
            if (cur_r == last_r)
            begin
               st_nxt = st_idle;
               fin    = 1'b1;
            end
         end
         st_idle:
         begin
            if (req.valid)
            begin
               unique case (req.cmd)
                  flash_pkg::cmd_read:
                  begin
                     rd_ok   = 1'b1;
                     rd_byte = mem[req.addr];
                  end
                  flash_pkg::read_discovery_table_cmd:
                  begin
                     rd_ok   = 1'b1;
                     rd_byte = drd;
                  end
                  flash_pkg::cmd_sec_read:
                  begin
                     rd_ok   = sec_ok;
                     rej     = !sec_ok;
                     rd_byte = srd[sn];
                  end
                  flash_pkg::cmd_page_prog: fin = 1'b1;
                  flash_pkg::cmd_prog_data:
                  begin
                     mwe = open_r;
                     mwa = {page_r, off_r};
                     fin = open_r;
                     rej = !open_r;
                  end
                  flash_pkg::cmd_sector_erase,
                  flash_pkg::cmd_block_erase,
                  flash_pkg::cmd_chip_erase: st_nxt = st_erase;
                  flash_pkg::cmd_sec_prog:
                  begin
                     if (sec_ok && !locked[sn])
                     begin
                        swe[sn] = 1'b1;
                        swa     = req.addr[9:0];
                        fin     = 1'b1;
                     end
                     else
                        rej = 1'b1;
                  end
                  flash_pkg::cmd_sec_erase:
                  begin
                     if (sec_ok && !locked[sn])
                        st_nxt = st_sec_erase;
                     else
                        rej = 1'b1;
                  end
                  flash_pkg::cmd_sec_lock:
                  begin
                     slock[sn] = sec_ok;
                     fin       = sec_ok;
                     rej       = !sec_ok;
                  end
                  default: rej = 1'b1;
               endcase
            end
         end
      endcase
   end

   // Erase walker
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_r   <= st_idle;
         cur_r  <= 24'h0;
         last_r <= 24'h0;
         sel_r  <= 2'h0;
         busy_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         busy_r <= (st_nxt != st_idle);
         if (st_r == st_idle && st_nxt == st_erase)
         begin
            if (req.cmd == flash_pkg::cmd_sector_erase)
            begin
               cur_r  <= {req.addr[23:12], 12'h000};
               last_r <= {req.addr[23:12], `SECTOR_LAST_OFS};
            end
            else if (req.cmd == flash_pkg::cmd_block_erase)
            begin
               cur_r  <= {req.addr[23:16], 16'h0000};
               last_r <= {req.addr[23:16], `BLOCK_LAST_OFS};
            end
            else
            begin
               cur_r  <= `CHIP_FIRST;
               last_r <= `CHIP_LAST;
            end
         end
         else if (st_r == st_idle && st_nxt == st_sec_erase)
         begin
            cur_r  <= 24'h0;
            last_r <= `SEC_ERASE_LAST;
            sel_r  <= sn;
         end
         else if (st_r != st_idle)
            cur_r <= cur_r + 24'h1;
      end
   end

   // Open page for program data
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         page_r <= 16'h0;
         off_r  <= 8'h0;
         open_r <= 1'b0;
      end
      else if (idle_req)
      begin
         if (req.cmd == flash_pkg::cmd_page_prog)
         begin
            page_r <= req.addr[23:8];
            off_r  <= req.addr[7:0];
            open_r <= 1'b1;
         end
         else if (req.cmd == flash_pkg::cmd_prog_data)
            off_r <= off_r + 8'h1;
         else
            open_r <= 1'b0;
      end
   end

   // Main array: program clears bits, erase sets them
   always_ff @(posedge ref_clk)
   begin
      if (mwe)
         mem[mwa] <= mfill ? `ERASED : (mem[mwa] & req.data);
   end
   // Answer
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         resp_r <= '0;
      else
      begin
         resp_r.rd_valid <= rd_ok;
         resp_r.rd_data  <= rd_ok ? rd_byte : 8'h00;
         resp_r.done     <= fin;
         resp_r.rejected <= rej;
      end
   end

   for (genvar g = 0; g < 3; g++)
   begin : g_sec
      sec_reg u_sec
      (
         .ref_clk  (ref_clk),
         .wr_en    (swe[g]),
         .wr_fill  (sfill),
         .wr_addr  (swa),
         .wr_data  (req.data),
         .lock_set (slock[g]),
         .rd_addr  (req.addr[9:0]),
         .rd_data  (srd[g]),
         .locked   (locked[g])
      );
   end

   disc_rom u_disc
   (
      .addr (req.addr),
      .data (drd)
   );
   assign resp = resp_r;
   assign busy = busy_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   property p_disc_sig;
      disc_rd && req.addr == 24'h0 |=> resp_r.rd_valid && resp_r.rd_data == HDR0[7:0];
   endproperty
   a_disc_sig: assert property (p_disc_sig) else $error("signature byte wrong");
   property p_disc_rev;
      disc_rd && req.addr == 24'h5 |=> resp_r.rd_data == HDR0[47:40];
   endproperty
   a_disc_rev: assert property (p_disc_rev) else $error("major revision wrong");
   property p_disc_proto;
      disc_rd && req.addr == 24'h7 |=> resp_r.rd_data == `ERASED;
   endproperty
   a_disc_proto: assert property (p_disc_proto) else $error("access protocol wrong");
   property p_disc_minor;
      disc_rd && req.addr == 24'h9 |=> resp_r.rd_data == HDR0[79:72];
   endproperty
   a_disc_minor: assert property (p_disc_minor) else $error("table minor wrong");
   property p_disc_ptr;
      disc_rd && req.addr == 24'hC |=> resp_r.rd_data == HDR0[103:96];
   endproperty
   a_disc_ptr: assert property (p_disc_ptr) else $error("table pointer wrong");
   property p_disc_rsv;
      disc_rd && req.addr[23:2] == 22'h1F |=> resp_r.rd_valid && resp_r.rd_data == `ERASED;
   endproperty
   a_disc_rsv: assert property (p_disc_rsv) else $error("reserved byte not erased");
   property p_disc_ro;
      st_r == st_idle |-> !(mwe && req.cmd == flash_pkg::read_discovery_table_cmd);
   endproperty
   a_disc_ro: assert property (p_disc_ro) else $error("discovery read wrote array");
   property p_lock_rej;
      idle_req && req.cmd == flash_pkg::cmd_sec_prog && sec_ok && locked[sn] |=> resp_r.rejected && !resp_r.done;
   endproperty
   a_lock_rej: assert property (p_lock_rej) else $error("locked register programmed");
   property p_lock_keep;
      locked != 3'h0 |=> (locked & $past(locked)) == $past(locked);
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
   property p_sec_one;
      $onehot0(swe);
   endproperty
   a_sec_one: assert property (p_sec_one) else $error("two security registers written");
   property p_sector_span;
      idle_req && req.cmd == flash_pkg::cmd_sector_erase
      |=> busy_r && cur_r[11:0] == 12'h000 && last_r == {cur_r[23:12], `SECTOR_LAST_OFS};
   endproperty
   a_sector_span: assert property (p_sector_span) else $error("sector erase misaligned");
   property p_page_bound;
      mwe && !mfill |-> mwa[23:8] == page_r;
   endproperty
   a_page_bound: assert property (p_page_bound) else $error("program left its page");
endmodule

// ---- flash_pkg.sv ----
/*
 Types shared by the flash store: command codes and request/answer carriers.
 Assumes flash_map.svh is reachable by bare name.
*/
package flash_pkg;
`include "flash_map.svh"

   typedef enum logic [7:0] {
      cmd_read                 = `OP_READ,
      cmd_page_prog            = `OP_PAGE_PROG,
      cmd_prog_data            = `OP_PROG_DATA,
      cmd_sector_erase         = `OP_SECTOR_ERASE,
      cmd_block_erase          = `OP_BLOCK_ERASE,
      cmd_chip_erase           = `OP_CHIP_ERASE,
      cmd_sec_read             = `OP_SEC_READ,
      cmd_sec_prog             = `OP_SEC_PROG,
      cmd_sec_erase            = `OP_SEC_ERASE,
      cmd_sec_lock             = `OP_SEC_LOCK,
      read_discovery_table_cmd = `OP_READ_DISC
   } cmd_t;

   typedef struct packed {
      logic        valid;
      cmd_t        cmd;
      logic [23:0] addr;
      logic [7:0]  data;
   } req_t;

   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
      logic       done;
      logic       rejected;
   } resp_t;

endpackage

// ---- sec_reg.sv ----
/*
 One 1024-byte security register with its one-time lock.
 Assumes the core gates writes by busy state; lock and contents are nonvolatile.
*/
`timescale 1ns/1ps
`include "flash_map.svh"
module sec_reg
(
   input  wire logic       ref_clk,
   input  wire logic       wr_en,
   input  wire logic       wr_fill,
   input  wire logic [9:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       lock_set,
   input  wire logic [9:0] rd_addr,
   output      logic [7:0] rd_data,
   output      logic       locked
);

   logic [7:0] mem [1024];
   logic       lock_r = 1'b0;

   // Program clears bits only, fill erases; both dead once locked
   always_ff @(posedge ref_clk)
   begin
      if (wr_en && !lock_r)
      begin
         mem[wr_addr] <= wr_fill ? `ERASED : (mem[wr_addr] & wr_data);
      end
   end

   // One-time lock, never cleared
   always_ff @(posedge ref_clk)
   begin
      if (lock_set)
      begin
         lock_r <= 1'b1;
      end
   end

   assign rd_data = mem[rd_addr];
   assign locked  = lock_r;

endmodule

// ---- testbench.sv ----
/*
 Self-checking bench for the flash storage core.
 Assumes the command host model and the core are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
   localparam int RD = 0;
   localparam int OK = 1;
   localparam int NO = 2;
   localparam logic [19:0] DISC [23] = '{20'h00053, 20'h00146, 20'h00244, 20'h00350, 20'h00408,
      20'h00501, 20'h00601, 20'h007FF, 20'h00800, 20'h00907, 20'h00A01, 20'h00B10, 20'h00C30,
      20'h00D00, 20'h00E00, 20'h00FFF, 20'h020FF, 20'h02FFF, 20'h030E5, 20'h03120, 20'h07CFF,
      20'h0FFFF, 20'h100FF};

   logic             ref_clk     = 1'b0;
   logic             srst        = 1'b1;
   flash_pkg::req_t  req;
   flash_pkg::resp_t resp;
   logic             busy;
   int               fail_count  = 0;
   int               checks      = 0;
   int               busy_cycles = 0;

   always #50 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
      if (busy === 1'b1)
         busy_cycles++;

   cmd_host u_cmd_host
   (
      .ref_clk (ref_clk),
      .req     (req)
   );

   flash_map_and_discovery_table u_flash_map_and_discovery_table
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .req     (req),
      .resp    (resp),
      .busy    (busy)
   );

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One request and its one-cycle answer
   task automatic op(input flash_pkg::cmd_t c, input logic [23:0] a, input logic [7:0] d,
                     input int kind, input logic [7:0] exp);
      u_cmd_host.send(c, a, d);
      check({21'h000000, resp.rd_valid, resp.done, resp.rejected, resp.rd_data},
            {21'h000000, kind == RD, kind == OK, kind == NO, (kind == RD) ? exp : 8'h00},
            $sformatf("answer at %h", a));
   endtask

   // Erase walk, optional refused request while busy
   task automatic erase(input flash_pkg::cmd_t c, input logic [23:0] a, input int len, input logic probe);
      int n;
      n = 0;
      busy_cycles = 0;
      u_cmd_host.send(c, a, 8'h00);
      @(negedge ref_clk);
      if (probe)
         op(flash_pkg::cmd_read, a, 8'h00, NO, 8'h00);
      while (busy === 1'b1 && n < len + 8)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= len + 8)
      begin
         fail_count++;
         complete_run();
      end
      check({31'h00000000, resp.done}, 32'h00000001, "erase done");
      check(busy_cycles, len, "busy length");
   endtask

   task automatic test_discovery();
      foreach (DISC[i])
         op(flash_pkg::read_discovery_table_cmd, {12'h000, DISC[i][19:8]}, 8'h00, RD, DISC[i][7:0]);
      $display("Test discovery contents finished");
   endtask

   task automatic test_main();
      erase(flash_pkg::cmd_sector_erase, 24'h001234, 4096, 1'b1);
      op(flash_pkg::cmd_read, 24'h001000, 8'h00, RD, 8'hFF);
      op(flash_pkg::cmd_read, 24'h001FFF, 8'h00, RD, 8'hFF);
      op(flash_pkg::cmd_page_prog, 24'h0012FF, 8'h00, OK, 8'h00);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'hF0, OK, 8'h00);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'h3C, OK, 8'h00);
      op(flash_pkg::cmd_page_prog, 24'h0012FF, 8'h00, OK, 8'h00);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'h0F, OK, 8'h00);
      op(flash_pkg::cmd_read, 24'h0012FF, 8'h00, RD, 8'h00);
      op(flash_pkg::cmd_read, 24'h001200, 8'h00, RD, 8'h3C);
      op(flash_pkg::cmd_read, 24'h001300, 8'h00, RD, 8'hFF);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_t'(8'h81), 24'h001200, 8'h00, NO, 8'h00);
      erase(flash_pkg::cmd_block_erase, 24'h02ABCD, 65536, 1'b0);
      op(flash_pkg::cmd_read, 24'h020000, 8'h00, RD, 8'hFF);
      op(flash_pkg::cmd_read, 24'h02FFFF, 8'h00, RD, 8'hFF);
      $display("Test main array finished");
   endtask

   task automatic test_disc_fixed();
      erase(flash_pkg::cmd_sector_erase, 24'h000000, 4096, 1'b0);
      op(flash_pkg::cmd_page_prog, 24'h000000, 8'h00, OK, 8'h00);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'h00, OK, 8'h00);
      op(flash_pkg::cmd_read, 24'h000001, 8'h00, RD, 8'hFF);
      op(flash_pkg::read_discovery_table_cmd, 24'h000000, 8'h00, RD, 8'h53);
      op(flash_pkg::read_discovery_table_cmd, 24'h000001, 8'h00, RD, 8'h46);
      $display("Test discovery space fixed finished");
   endtask

   task automatic test_security();
      erase(flash_pkg::cmd_sec_erase, 24'h001000, 1024, 1'b0);
      erase(flash_pkg::cmd_sec_erase, 24'h002000, 1024, 1'b0);
      op(flash_pkg::cmd_sec_prog, 24'h0013FF, 8'h12, OK, 8'h00);
      op(flash_pkg::cmd_sec_read, 24'h0013FF, 8'h00, RD, 8'h12);
      op(flash_pkg::cmd_sec_read, 24'h0023FF, 8'h00, RD, 8'hFF);
      op(flash_pkg::cmd_sec_read, 24'h001400, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_read, 24'h000010, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_read, 24'h004000, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_lock, 24'h001000, 8'h00, OK, 8'h00);
      op(flash_pkg::cmd_sec_prog, 24'h001000, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_erase, 24'h001000, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_read, 24'h0013FF, 8'h00, RD, 8'h12);
      op(flash_pkg::cmd_sec_prog, 24'h002000, 8'h34, OK, 8'h00);
      op(flash_pkg::cmd_sec_read, 24'h002000, 8'h00, RD, 8'h34);
      erase(flash_pkg::cmd_sec_erase, 24'h002000, 1024, 1'b0);
      op(flash_pkg::cmd_sec_read, 24'h002000, 8'h00, RD, 8'hFF);
      $display("Test security registers finished");
   endtask

   // Chip erase cut short by a reset in mid-run
   task automatic test_reset();
      u_cmd_host.send(flash_pkg::cmd_chip_erase, 24'h123456, 8'h00);
      check({30'h00000000, busy, |resp}, 32'h00000002, "chip erase start");
      repeat (100) @(negedge ref_clk);
      op(flash_pkg::cmd_sec_read, 24'h001000, 8'h00, NO, 8'h00);
      check({31'h00000000, busy}, 32'h00000001, "chip erase still busy");
      srst = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      check({30'h00000000, busy, |resp}, 32'h00000000, "outputs after reset");
      op(flash_pkg::read_discovery_table_cmd, 24'h000000, 8'h00, RD, 8'h53);
      op(flash_pkg::cmd_prog_data, 24'h000000, 8'h00, NO, 8'h00);
      op(flash_pkg::cmd_sec_prog, 24'h001000, 8'h00, NO, 8'h00);
      $display("Test reset during erase finished");
   endtask

   initial
   begin
      repeat (16) @(negedge ref_clk);
      check({30'h00000000, busy, |resp}, 32'h00000000, "reset outputs");
      srst = 1'b0;
      test_discovery();
      test_main();
      test_disc_fixed();
      test_security();
      test_reset();
      complete_run();
   end
endmodule
